/* File: logic/pch_top.sv */
`timescale 1ns/10ps
module pch_top (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// command byte stream
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_data_i,
	output logic byte_ready_o,
	// mode
	input wire logic standalone_i,
	// reply
	output logic reply_valid_o,
	output logic [7:0] reply_addr_o,
	output logic [7:0] reply_instr_o,
	output logic [7:0] reply_status_o,
	output logic [31:0] reply_value_o,
	// state
	output logic [31:0] accumulator_o,
	output logic ready_o
);

	pch_frame_if frm ();

	pch_pkg::pch_state_t state_r;
	pch_pkg::pch_state_t state_nxt;
	logic [7:0] init_idx_r;

	logic [7:0] addr_r;
	logic [7:0] instr_r;
	logic [7:0] ptype_r;
	logic [7:0] bank_r;
	logic [31:0] value_r;
	logic csum_ok_r;
	logic standalone_r;

	// working copies are volatile; the _nv arrays model the non-volatile store
	logic [31:0] axis_work [pch_pkg::PARAM_DEPTH];
	logic [31:0] axis_nv [pch_pkg::PARAM_DEPTH];
	logic [31:0] glob_settings [pch_pkg::PARAM_DEPTH];
	logic [31:0] glob_settings_nv [pch_pkg::PARAM_DEPTH];
	logic [31:0] glob_user [pch_pkg::PARAM_DEPTH];
	logic [31:0] glob_irq [pch_pkg::PARAM_DEPTH];

	logic axis_wr;
	logic axis_save;
	logic axis_reload;
	logic glob_wr;
	logic settings_wr;
	logic accu_load;
	logic [7:0] status_nxt;
	logic [31:0] value_nxt;

	// ****************************************
	// frame assembly
	// ****************************************
	pch_frame_rx u_frame_rx (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.byte_valid_i(byte_valid_i),
		.byte_data_i(byte_data_i),
		.byte_ready_o(byte_ready_o),
		.frm(frm)
	);

	assign frm.frame_take = (state_r == pch_pkg::PCH_ST_IDLE) && frm.frame_valid;
	assign ready_o = (state_r != pch_pkg::PCH_ST_INIT);

	// ****************************************
	// sequencing
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pch_pkg::PCH_ST_INIT: begin
				if (init_idx_r == pch_pkg::INIT_IDX_LAST) begin
					state_nxt = pch_pkg::PCH_ST_IDLE;
				end
			end
			pch_pkg::PCH_ST_IDLE: begin
				if (frm.frame_valid) begin
					state_nxt = pch_pkg::PCH_ST_EXEC;
				end
			end
			pch_pkg::PCH_ST_EXEC: state_nxt = pch_pkg::PCH_ST_IDLE;
			default: state_nxt = pch_pkg::PCH_ST_INIT;
		endcase
	end

	// walk all entries after reset before taking frames
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_r <= pch_pkg::PCH_ST_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// restore index runs only while walking
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			init_idx_r <= pch_pkg::INIT_IDX_RESET;
		end else if (state_r == pch_pkg::PCH_ST_INIT) begin
			init_idx_r <= init_idx_r + 8'h01;
		end
	end

	// ****************************************
	// command capture
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			addr_r <= 8'h00;
			instr_r <= 8'h00;
			ptype_r <= 8'h00;
			bank_r <= 8'h00;
			value_r <= 32'h0000_0000;
			csum_ok_r <= 1'b0;
		end else if (frm.frame_take) begin
			addr_r <= frm.addr;
			instr_r <= frm.instr;
			ptype_r <= frm.ptype;
			bank_r <= frm.bank;
			value_r <= frm.value;
			csum_ok_r <= frm.csum_ok;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			standalone_r <= 1'b0;
		end else if (frm.frame_take) begin
			// mode is sampled per command so a mid-command change has no effect
			standalone_r <= standalone_i;
		end
	end

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		axis_wr = 1'b0;
		axis_save = 1'b0;
		axis_reload = 1'b0;
		glob_wr = 1'b0;
		accu_load = 1'b0;
		status_nxt = pch_pkg::STATUS_OK;
		value_nxt = 32'h0000_0000;
		if (!csum_ok_r) begin
			status_nxt = pch_pkg::STATUS_BAD_CSUM;
		end else begin
			case (instr_r)
				pch_pkg::SET_AXIS_PARAM_CMD: begin
					if (bank_r != pch_pkg::AXIS_MOTOR) begin
						status_nxt = pch_pkg::STATUS_BAD_VALUE;
					end else begin
						axis_wr = 1'b1;
					end
				end
				pch_pkg::READ_AXIS_PARAM_CMD: begin
					if (bank_r != pch_pkg::AXIS_MOTOR) begin
						status_nxt = pch_pkg::STATUS_BAD_VALUE;
					end else begin
						value_nxt = axis_work[ptype_r];
						accu_load = standalone_r;
					end
				end
				pch_pkg::SAVE_AXIS_PARAM_CMD: begin
					if (bank_r != pch_pkg::AXIS_MOTOR) begin
						status_nxt = pch_pkg::STATUS_BAD_VALUE;
					end else begin
						axis_save = 1'b1;
					end
				end
				pch_pkg::RELOAD_AXIS_PARAM_CMD: begin
					if (bank_r != pch_pkg::AXIS_MOTOR) begin
						status_nxt = pch_pkg::STATUS_BAD_VALUE;
					end else begin
						axis_reload = 1'b1;
					end
				end
				pch_pkg::WRITE_GLOBAL_PARAM_CMD: begin
					case (bank_r)
						pch_pkg::BANK_SETTINGS,
						pch_pkg::BANK_USER_VARS,
						pch_pkg::BANK_IRQ_CFG: glob_wr = 1'b1;
						default: status_nxt = pch_pkg::STATUS_BAD_VALUE;
					endcase
				end
				pch_pkg::READ_GLOBAL_PARAM_CMD: begin
					case (bank_r)
						pch_pkg::BANK_SETTINGS: value_nxt = glob_settings[ptype_r];
						pch_pkg::BANK_USER_VARS: value_nxt = glob_user[ptype_r];
						pch_pkg::BANK_IRQ_CFG: value_nxt = glob_irq[ptype_r];
						default: status_nxt = pch_pkg::STATUS_BAD_VALUE;
					endcase
					accu_load = standalone_r && (status_nxt == pch_pkg::STATUS_OK);
				end
				default: status_nxt = pch_pkg::STATUS_BAD_CMD;
			endcase
		end
	end

	// ****************************************
	// axis parameter storage
	// ****************************************
	// no reset on the arrays: the nv copy must survive srst, and the
	// working copy is refilled from it by the init walk
	always_ff @(posedge clk_sys_i) begin
		if (state_r == pch_pkg::PCH_ST_INIT) begin
			axis_work[init_idx_r] <= axis_nv[init_idx_r];
		end else if (state_r == pch_pkg::PCH_ST_EXEC) begin
			if (axis_wr) begin
				axis_work[ptype_r] <= value_r;
			end else if (axis_reload) begin
				axis_work[ptype_r] <= axis_nv[ptype_r];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (state_r == pch_pkg::PCH_ST_EXEC && axis_save) begin
			axis_nv[ptype_r] <= axis_work[ptype_r];
		end
	end

	// ****************************************
	// global parameter banks
	// ****************************************
	assign settings_wr = (state_r == pch_pkg::PCH_ST_EXEC) && glob_wr &&
		(bank_r == pch_pkg::BANK_SETTINGS);

	always_ff @(posedge clk_sys_i) begin
		if (state_r == pch_pkg::PCH_ST_INIT) begin
			// bank 0 returns from its nv copy; banks 2 and 3 have none
			glob_settings[init_idx_r] <= glob_settings_nv[init_idx_r];
		end else if (settings_wr) begin
			glob_settings[ptype_r] <= value_r;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (state_r == pch_pkg::PCH_ST_EXEC && glob_wr) begin
			case (bank_r)
				pch_pkg::BANK_USER_VARS: glob_user[ptype_r] <= value_r;
				pch_pkg::BANK_IRQ_CFG: glob_irq[ptype_r] <= value_r;
				default: glob_irq[ptype_r] <= glob_irq[ptype_r];
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (settings_wr) begin
			glob_settings_nv[ptype_r] <= value_r;
		end
	end

	// ****************************************
	// accumulator
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			accumulator_o <= pch_pkg::ACCU_RESET;
		end else if (state_r == pch_pkg::PCH_ST_EXEC && accu_load) begin
			accumulator_o <= value_nxt;
		end
	end

	// ****************************************
	// reply
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			reply_valid_o <= 1'b0;
		end else begin
			reply_valid_o <= (state_r == pch_pkg::PCH_ST_EXEC);
		end
	end

	// fields stand until the next reply so a slow host can still read them
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			reply_addr_o <= 8'h00;
			reply_instr_o <= 8'h00;
			reply_status_o <= 8'h00;
			reply_value_o <= 32'h0000_0000;
		end else if (state_r == pch_pkg::PCH_ST_EXEC) begin
			reply_addr_o <= addr_r;
			reply_instr_o <= instr_r;
			// status and value of the command
			reply_status_o <= status_nxt;
			reply_value_o <= value_nxt;
		end
	end

endmodule

/* File: logic/pch_pkg.sv */
// Function
// - A set-axis-parameter frame writes its 32-bit value into the axis parameter named by the type byte.
// - Every axis command carries 0 in the motor/bank byte, since there is only one axis.
// - A read-axis-parameter frame returns the current value of the axis parameter named by the type byte.
// - A read-axis-parameter command run in standalone mode also loads the value read into the accumulator.
// - A read-axis-parameter command run in direct mode reports the value in the reply only and leaves the accumulator alone.
// - A successful read in direct mode replies with status 100 and the value read.
// - A save-axis-parameter frame copies the axis parameter to non-volatile memory, ignores the value field and replies 100 with value 0.
// - A reload-axis-parameter frame restores the axis parameter from its non-volatile copy, ignores the value field and replies 100.
// - After power-up every axis parameter is reloaded from its non-volatile copy before any command is accepted.
// - A write-global-parameter frame writes its value into the type-selected parameter of bank 0, 2 or 3.
// - Bank 0 holds module settings, bank 2 holds user variables and bank 3 holds interrupt configuration.
// - A write to bank 0 is saved to non-volatile memory at once, with no separate store command.
// - Every global parameter of every bank reads back through the read-global-parameter command.
// - A frame is address, instruction, type, motor/bank, four value bytes most significant first, then checksum.
// - Axis parameters written by command live in working memory only and are lost at power-off unless saved.
package pch_pkg;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int FRAME_LEN = 9;
	localparam logic [3:0] BYTE_IDX_LAST = 4'h8;
	localparam logic [3:0] BYTE_IDX_ADDR = 4'h0;
	localparam logic [3:0] BYTE_IDX_INSTR = 4'h1;
	localparam logic [3:0] BYTE_IDX_TYPE = 4'h2;
	localparam logic [3:0] BYTE_IDX_BANK = 4'h3;
	localparam logic [3:0] BYTE_IDX_VAL3 = 4'h4;
	localparam logic [3:0] BYTE_IDX_VAL2 = 4'h5;
	localparam logic [3:0] BYTE_IDX_VAL1 = 4'h6;
	localparam logic [3:0] BYTE_IDX_VAL0 = 4'h7;

	// ****************************************
	// instruction codes
	// ****************************************
	localparam logic [7:0] SET_AXIS_PARAM_CMD = 8'h05;
	localparam logic [7:0] READ_AXIS_PARAM_CMD = 8'h06;
	localparam logic [7:0] SAVE_AXIS_PARAM_CMD = 8'h07;
	localparam logic [7:0] RELOAD_AXIS_PARAM_CMD = 8'h08;
	localparam logic [7:0] WRITE_GLOBAL_PARAM_CMD = 8'h09;
	localparam logic [7:0] READ_GLOBAL_PARAM_CMD = 8'h0A;

	// ****************************************
	// banks and axis
	// ****************************************
	localparam logic [7:0] AXIS_MOTOR = 8'h00;
	localparam logic [7:0] BANK_SETTINGS = 8'h00;
	localparam logic [7:0] BANK_USER_VARS = 8'h02;
	localparam logic [7:0] BANK_IRQ_CFG = 8'h03;
	localparam int PARAM_DEPTH = 256;

	// ****************************************
	// reply status codes
	// ****************************************
	localparam logic [7:0] STATUS_OK = 8'h64;
	localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
	localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] ACCU_RESET = 32'h0000_0000;
	localparam logic [7:0] INIT_IDX_RESET = 8'h00;
	localparam logic [7:0] INIT_IDX_LAST = 8'hFF;

	typedef enum logic [1:0] {
		PCH_ST_INIT,
		PCH_ST_IDLE,
		PCH_ST_EXEC
	} pch_state_t;

endpackage

/* File: logic/pch_frame_if.sv */
`timescale 1ns/10ps
interface pch_frame_if;
	logic frame_valid;
	logic frame_take;
	logic csum_ok;
	logic [7:0] addr;
	logic [7:0] instr;
	logic [7:0] ptype;
	logic [7:0] bank;
	logic [31:0] value;

	modport rx (
		output frame_valid,
		input frame_take,
		output csum_ok,
		output addr,
		output instr,
		output ptype,
		output bank,
		output value
	);

	modport exe (
		input frame_valid,
		output frame_take,
		input csum_ok,
		input addr,
		input instr,
		input ptype,
		input bank,
		input value
	);
endinterface

/* File: logic/pch_frame_rx.sv */
`timescale 1ns/10ps
module pch_frame_rx (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// byte stream
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_data_i,
	output logic byte_ready_o,
	// assembled frame
	pch_frame_if.rx frm
);

	logic [3:0] idx_r;
	logic [7:0] sum_r;
	logic hold_r;
	logic take_byte;

	// a held frame stalls the stream so nothing is overwritten before execution
	assign byte_ready_o = !hold_r;
	assign take_byte = byte_valid_i && !hold_r;
	assign frm.frame_valid = hold_r;

	// ****************************************
	// byte position and checksum
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			idx_r <= pch_pkg::BYTE_IDX_ADDR;
			sum_r <= 8'h00;
		end else if (take_byte) begin
			if (idx_r == pch_pkg::BYTE_IDX_LAST) begin
				idx_r <= pch_pkg::BYTE_IDX_ADDR;
				sum_r <= 8'h00;
			end else begin
				idx_r <= idx_r + 4'h1;
				sum_r <= sum_r + byte_data_i;
			end
		end
	end

	// ****************************************
	// field capture
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			frm.addr <= 8'h00;
			frm.instr <= 8'h00;
			frm.ptype <= 8'h00;
			frm.bank <= 8'h00;
			frm.value <= 32'h0000_0000;
			frm.csum_ok <= 1'b0;
		end else if (take_byte) begin
			// fixed field order, value msb first
			case (idx_r)
				pch_pkg::BYTE_IDX_ADDR: frm.addr <= byte_data_i;
				pch_pkg::BYTE_IDX_INSTR: frm.instr <= byte_data_i;
				pch_pkg::BYTE_IDX_TYPE: frm.ptype <= byte_data_i;
				pch_pkg::BYTE_IDX_BANK: frm.bank <= byte_data_i;
				pch_pkg::BYTE_IDX_VAL3: frm.value[31:24] <= byte_data_i;
				pch_pkg::BYTE_IDX_VAL2: frm.value[23:16] <= byte_data_i;
				pch_pkg::BYTE_IDX_VAL1: frm.value[15:8] <= byte_data_i;
				pch_pkg::BYTE_IDX_VAL0: frm.value[7:0] <= byte_data_i;
				pch_pkg::BYTE_IDX_LAST: frm.csum_ok <= (sum_r == byte_data_i);
				default: frm.csum_ok <= frm.csum_ok;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			hold_r <= 1'b0;
		end else if (take_byte && idx_r == pch_pkg::BYTE_IDX_LAST) begin
			hold_r <= 1'b1;
		end else if (frm.frame_take) begin
			hold_r <= 1'b0;
		end
	end

endmodule

/* File: verification/pch_chk.sv */
`timescale 1ns/10ps
module pch_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// byte stream and mode
	input wire logic byte_valid_i,
	input wire logic byte_ready_o,
	input wire logic standalone_i,
	// reply and state
	input wire logic reply_valid_o,
	input wire logic [7:0] reply_status_o,
	input wire logic [31:0] reply_value_o,
	input wire logic [31:0] accumulator_o,
	input wire logic ready_o
);
	// ****
	// frame tracking
	// ****
	logic [3:0] idx_r;
	logic [8:0] up_r;
	logic mode_r;
	logic last_w;
	assign last_w = byte_valid_i && byte_ready_o && idx_r == pch_pkg::BYTE_IDX_LAST;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || last_w) begin
			idx_r <= 4'h0;
		end else if (byte_valid_i && byte_ready_o) begin
			idx_r <= idx_r + 4'h1;
		end
	end
	// saturates at the walk length, so a short or long walk shows
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			up_r <= 9'h000;
		end else if (!up_r[8]) begin
			up_r <= up_r + 9'h001;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (last_w) begin
			mode_r <= standalone_i;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	// ****
	// properties
	// ****
	// walk length
	AST_WALK_LEN: assert property (ready_o == up_r[8])
		else $error("ready timing wrong");
	AST_NO_EARLY: assert property (!ready_o |-> !reply_valid_o)
		else $error("reply during restore");
	AST_HOLD_FULL: assert property (last_w |=> !byte_ready_o)
		else $error("ready after ninth byte");
	AST_LATENCY: assert property (last_w && ready_o |-> ##3 reply_valid_o)
		else $error("reply latency wrong");
	AST_PULSE: assert property (reply_valid_o |=> !reply_valid_o)
		else $error("reply pulse too long");
	AST_FIELDS: assert property (!reply_valid_o |-> $stable(reply_status_o) && $stable(reply_value_o))
		else $error("reply fields moved");
	AST_ACCU_REPLY: assert property ($changed(accumulator_o) |-> reply_valid_o)
		else $error("accumulator moved alone");
	AST_ACCU_DIRECT: assert property (reply_valid_o && !mode_r |-> $stable(accumulator_o))
		else $error("accumulator changed in direct mode");
	AST_ERR_ZERO: assert property (reply_valid_o && reply_status_o != pch_pkg::STATUS_OK
		|-> reply_value_o == 32'h0000_0000)
		else $error("error reply carries value");
	cover property (reply_valid_o && reply_status_o == pch_pkg::STATUS_OK);
	cover property (reply_valid_o && reply_status_o == pch_pkg::STATUS_BAD_CSUM);
	cover property (reply_valid_o && mode_r && $changed(accumulator_o));
	cover property (!ready_o && byte_valid_i && byte_ready_o);
endmodule

/* File: verification/pch_host.sv */
`timescale 1ns/10ps
module pch_host (
	// clock
	input wire logic clk_sys_i,
	// byte stream
	output logic byte_valid_o,
	output logic [7:0] byte_data_o,
	input wire logic byte_ready_i
);
	int seed = 32'h5e96;
	initial begin
		byte_valid_o = 1'b0;
		byte_data_o = 8'h00;
	end
	task automatic send(input logic [7:0] ins, input logic [7:0] pt, input logic [7:0] bk,
		input logic [31:0] val, input logic [7:0] cerr);
		logic [63:0] f;
		logic [7:0] cs;
		int n;
		f = {8'h01, ins, pt, bk, val};
		cs = cerr;
		for (int i = 0; i < 8; i++) begin
			cs = cs + f[63 - 8 * i -: 8];
		end
		for (int i = 0; i < 9; i++) begin
			// random idle gaps; a released line keeps changing
			repeat ($random(seed) & 3) begin
				byte_valid_o = 1'b0;
				byte_data_o = ~byte_data_o;
				@(posedge clk_sys_i);
				#1;
			end
			byte_valid_o = 1'b1;
			byte_data_o = (i < 8) ? f[63 - 8 * i -: 8] : cs;
			n = 0;
			while (!byte_ready_i && n < 400) begin
				@(posedge clk_sys_i);
				#1;
				n++;
			end
			@(posedge clk_sys_i);
			#1;
		end
		byte_valid_o = 1'b0;
		byte_data_o = ~byte_data_o;
	endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic standalone_i = 1'b0;
	logic byte_valid_i;
	logic [7:0] byte_data_i;
	logic byte_ready_o;
	logic reply_valid_o;
	logic ready_o;
	logic [7:0] reply_addr_o;
	logic [7:0] reply_instr_o;
	logic [7:0] reply_status_o;
	logic [31:0] reply_value_o;
	logic [31:0] accumulator_o;
	logic [31:0] acc_m;
	logic [31:0] v;
	logic [7:0] t;
	logic [7:0] bk;
	int fails = 0;
	int num_checks = 0;
	int seed = 32'h5e96;
	always #2.5 clk_sys_i = ~clk_sys_i;
	pch_top i_pch_top (.clk_sys_i, .srst_i, .byte_valid_i, .byte_data_i, .byte_ready_o,
		.standalone_i, .reply_valid_o, .reply_addr_o, .reply_instr_o, .reply_status_o,
		.reply_value_o, .accumulator_o, .ready_o);
	pch_host i_pch_host (.clk_sys_i, .byte_valid_o(byte_valid_i), .byte_data_o(byte_data_i),
		.byte_ready_i(byte_ready_o));
	// ****
	// tasks
	// ****
	task automatic give_verdict;
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// accumulator after a reply: only a good read in standalone mode loads it
	function automatic logic [31:0] acc_exp(input logic [7:0] ins, input logic [7:0] st,
		input logic sa, input logic [31:0] rd, input logic [31:0] old);
		if (st == pch_pkg::STATUS_OK && sa && (ins == pch_pkg::READ_AXIS_PARAM_CMD ||
			ins == pch_pkg::READ_GLOBAL_PARAM_CMD)) begin
			return rd;
		end
		return old;
	endfunction
	task automatic do_reset(input logic wait_rdy);
		int n;
		srst_i = 1'b1;
		acc_m = 32'h0000_0000;
		repeat (12) @(posedge clk_sys_i);
		#1 srst_i = 1'b0;
		n = 0;
		// without the wait the next frame arrives during the restore walk
		while (wait_rdy && ready_o !== 1'b1 && n < 400) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (n >= 400) begin
			check(32'h0000_0000, 32'h0000_0001);
			give_verdict();
		end
	endtask
	task automatic cmd(input logic [7:0] ins, input logic [7:0] pt, input logic [7:0] b,
		input logic [31:0] val, input logic [7:0] cerr, input logic sa,
		input logic [7:0] est, input logic [31:0] evl);
		int n;
		standalone_i = sa;
		i_pch_host.send(ins, pt, b, val, cerr);
		n = 0;
		// long enough for a frame held through the whole restore walk
		while (reply_valid_o !== 1'b1 && n < 300) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (n >= 300) begin
			check(32'h0000_0000, 32'h0000_0001);
			give_verdict();
		end
		check({24'h00_0000, reply_status_o}, {24'h00_0000, est});
		check({24'h00_0000, reply_instr_o}, {24'h00_0000, ins});
		check({24'h00_0000, reply_addr_o}, 32'h0000_0001);
		check(reply_value_o, evl);
		acc_m = acc_exp(ins, est, sa, evl, acc_m);
		check(accumulator_o, acc_m);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		do_reset(1'b1);
		for (int k = 0; k < 24; k++) begin
			t = 8'($random(seed));
			v = $random(seed);
			bk = (k % 4 == 2) ? 8'h03 : {6'h00, k[0], 1'b0};
			if (k % 4 == 3) begin
				cmd(pch_pkg::SET_AXIS_PARAM_CMD, t, 8'h00, v, 8'h00, k[2], 8'h64, 32'h0);
				cmd(pch_pkg::READ_AXIS_PARAM_CMD, t, 8'h00, ~v, 8'h00, k[3], 8'h64, v);
			end else begin
				cmd(pch_pkg::WRITE_GLOBAL_PARAM_CMD, t, bk, v, 8'h00, k[2], 8'h64, 32'h0);
				cmd(pch_pkg::READ_GLOBAL_PARAM_CMD, t, bk, ~v, 8'h00, k[3], 8'h64, v);
			end
		end
		cmd(pch_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h0000_03E8, 8'h00, 1'b0, 8'h64, 0);
		cmd(pch_pkg::SAVE_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'hDEAD_BEEF, 8'h00, 1'b0, 8'h64, 0);
		cmd(pch_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h1234_5678, 8'h00, 1'b1, 8'h64, 0);
		cmd(pch_pkg::RELOAD_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h5555_AAAA, 8'h00, 1'b0, 8'h64, 0);
		cmd(pch_pkg::READ_AXIS_PARAM_CMD, 8'h04, 8'h00, 0, 8'h00, 1'b1, 8'h64, 32'h0000_03E8);
		cmd(pch_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h1234_5678, 8'h00, 1'b0, 8'h64, 0);
		cmd(pch_pkg::WRITE_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 32'h3, 8'h00, 1'b0, 8'h64, 0);
		do_reset(1'b1);
		cmd(pch_pkg::READ_AXIS_PARAM_CMD, 8'h04, 8'h00, 0, 8'h00, 1'b0, 8'h64, 32'h0000_03E8);
		cmd(pch_pkg::READ_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 0, 8'h00, 1'b1, 8'h64, 32'h3);
		// refused frames must leave everything unchanged
		cmd(pch_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h7, 8'h01, 1'b0, 8'h01, 0);
		cmd(pch_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h01, 32'h7, 8'h00, 1'b0, 8'h04, 0);
		cmd(pch_pkg::WRITE_GLOBAL_PARAM_CMD, 8'h42, 8'h01, 32'h7, 8'h00, 1'b0, 8'h04, 0);
		cmd(pch_pkg::READ_AXIS_PARAM_CMD, 8'h04, 8'h01, 0, 8'h00, 1'b1, 8'h04, 0);
		cmd(8'h33, 8'h00, 8'h00, 32'h7, 8'h00, 1'b0, 8'h02, 0);
		cmd(pch_pkg::READ_AXIS_PARAM_CMD, 8'h04, 8'h00, 0, 8'h00, 1'b1, 8'h64, 32'h0000_03E8);
		cmd(pch_pkg::READ_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 0, 8'h00, 1'b0, 8'h64, 32'h3);
		// a frame sent during the restore walk is held until the walk ends
		do_reset(1'b0);
		cmd(pch_pkg::READ_AXIS_PARAM_CMD, 8'h04, 8'h00, 0, 8'h00, 1'b1, 8'h64, 32'h0000_03E8);
		give_verdict();
	end
endmodule
bind pch_top pch_chk i_pch_chk (.clk_sys_i, .srst_i, .byte_valid_i, .byte_ready_o,
	.standalone_i, .reply_valid_o, .reply_status_o, .reply_value_o, .accumulator_o, .ready_o);
